// ==== hdl/core_sfr_regs.vh ====
// Addresses, reset values, field positions and operation codes of the core register set
`ifndef CORE_SFR_REGS_VH
`define CORE_SFR_REGS_VH

// Register addresses (also the APB word index; byte address is index times four)
`define ADDR_STACK_POINTER      8'h81
`define ADDR_DATA_POINTER_LOW   8'h82
`define ADDR_DATA_POINTER_HIGH  8'h83
`define ADDR_PROGRAM_STATUS     8'hD0
`define ADDR_ARITH_PRIMARY      8'hE0
`define ADDR_SECOND_OPERAND     8'hF0

// Reset values
`define RST_STACK_POINTER       8'h07
`define RST_DATA_POINTER_LOW    8'h00
`define RST_DATA_POINTER_HIGH   8'h00
`define RST_PROGRAM_STATUS      8'h00
`define RST_ARITH_PRIMARY       8'h00
`define RST_SECOND_OPERAND      8'h00

// Status word field positions
`define PSW_CARRY               7
`define PSW_AUX_CARRY           6
`define PSW_USER_FLAG_ZERO      5
`define PSW_BANK_HI             4
`define PSW_BANK_LO             3
`define PSW_SIGNED_WRAP         2
`define PSW_USER_FLAG_ONE       1
`define PSW_PARITY              0

// Arithmetic operation codes
`define OP_ADD                  3'h1
`define OP_ADDC                 3'h2
`define OP_SUBB                 3'h3
`define OP_PRODUCT              3'h4
`define OP_DIVIDE               3'h5

// Bank geometry and misc widths
`define BANK_SHIFT              3
`define BYTE_MAX                16'h00FF
`define APB_WORD_LSB            2
`define BIT_SEL_MSB             2

`endif

// ==== hdl/core_special_register_set.v ====
// Core special-function register set with APB access and execution-side ports
//
// Contract
// - Accumulator at E0H, bit-addressable, resets zero
// - Second operand at F0H, bit-addressable, resets zero
// - Push increments stack pointer before writing
// - Stack pointer at 81H resets to seven
// - Data pointer low byte at 82H
// - Data pointer high byte at 83H
// - Status word at D0H, parity read-only
// - Bank bits select register bank base
// - Add/subtract set signed wrap from carries
// - Product and divide signed wrap handling
`timescale 1ns/1ps
`include "core_sfr_regs.vh"

module core_special_register_set (
  input  wire        I_CLK,
  input  wire        I_SYS_RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [9:0]  PADDR,
  input  wire [31:0] PWDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  output reg  [31:0] PRDATA,
  input  wire        i_sfr_we,
  input  wire [7:0]  i_sfr_addr,
  input  wire [7:0]  i_sfr_wdata,
  output reg  [7:0]  o_sfr_rdata,
  input  wire        i_bit_we,
  input  wire [7:0]  i_bit_addr,
  input  wire        i_bit_val,
  input  wire        i_push,
  input  wire [7:0]  i_push_data,
  input  wire        i_pop,
  output reg         o_stack_we,
  output reg  [7:0]  o_stack_addr,
  output reg  [7:0]  o_stack_wdata,
  input  wire        i_arith_go,
  input  wire [2:0]  i_arith_op,
  input  wire [7:0]  i_arith_opnd,
  output reg  [7:0]  o_arith_primary,
  output reg  [7:0]  o_second_operand,
  output reg  [7:0]  o_stack_pointer,
  output reg  [15:0] o_data_pointer_pair,
  output reg  [7:0]  o_program_status_word,
  output reg  [7:0]  o_bank_base
);

  reg  [7:0]  arith_primary;
  reg  [7:0]  second_operand;
  reg  [7:0]  stack_pointer;
  reg  [7:0]  data_pointer_low;
  reg  [7:0]  data_pointer_high;
  reg  [7:1]  status_bits;
  reg  [7:0]  next_arith_primary;
  reg  [7:0]  next_second_operand;
  reg  [7:0]  next_stack_pointer;
  reg  [7:0]  next_data_pointer_low;
  reg  [7:0]  next_data_pointer_high;
  reg  [7:1]  next_status_bits;

  // Parity has no flop, so only the upper seven reset bits are stored
  localparam [7:0] reset_status_word = `RST_PROGRAM_STATUS;

  wire        parity;
  wire [7:0]  status_word;
  wire [7:0]  apb_index;
  wire        apb_aligned;
  wire        apb_hit;
  wire        apb_write;
  wire [7:0]  bit_byte;
  wire [2:0]  bit_pos;
  wire        carry_in;

  // Arithmetic intermediates
  wire [8:0]  add_full;
  wire [7:0]  add_low7;
  wire [4:0]  add_nib;
  wire [8:0]  sub_full;
  wire [7:0]  sub_low7;
  wire [4:0]  sub_nib;
  wire [15:0] product;
  wire [7:0]  quotient;
  wire [7:0]  remainder;

  // Parity follows the accumulator with no write path of its own
  assign parity      = ^arith_primary;
  assign status_word = {status_bits, parity};

  // Printed offsets 81H-83H are not word aligned, so all printed offsets act as word indices
  assign apb_index   = PADDR[9:`APB_WORD_LSB];
  assign apb_aligned = (PADDR[`APB_WORD_LSB-1:0] == 2'b00);
  assign apb_hit     = apb_aligned && is_mapped(apb_index);
  assign apb_write   = PSEL && PENABLE && PWRITE && apb_hit;
  assign PREADY      = 1'b1;
  assign PSLVERR     = PSEL && PENABLE && !apb_hit;

  assign bit_byte    = {i_bit_addr[7:`BIT_SEL_MSB+1], 3'b000};
  assign bit_pos     = i_bit_addr[`BIT_SEL_MSB:0];
  assign carry_in    = (i_arith_op == `OP_ADD) ? 1'b0 : status_bits[`PSW_CARRY];

  assign add_full    = {1'b0, arith_primary} + {1'b0, i_arith_opnd} + {8'h00, carry_in};
  assign add_low7    = {1'b0, arith_primary[6:0]} + {1'b0, i_arith_opnd[6:0]}
                       + {7'h00, carry_in};
  assign add_nib     = {1'b0, arith_primary[3:0]} + {1'b0, i_arith_opnd[3:0]}
                       + {4'h0, carry_in};
  assign sub_full    = {1'b0, arith_primary} - {1'b0, i_arith_opnd} - {8'h00, carry_in};
  assign sub_low7    = {1'b0, arith_primary[6:0]} - {1'b0, i_arith_opnd[6:0]}
                       - {7'h00, carry_in};
  assign sub_nib     = {1'b0, arith_primary[3:0]} - {1'b0, i_arith_opnd[3:0]}
                       - {4'h0, carry_in};
  assign product     = arith_primary * second_operand;
  // Divisor of zero is guarded so the divider never sees it
  assign quotient    = (second_operand == 8'h00) ? arith_primary
                       : arith_primary / second_operand;
  assign remainder   = (second_operand == 8'h00) ? second_operand
                       : arith_primary % second_operand;

  function is_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `ADDR_STACK_POINTER, `ADDR_DATA_POINTER_LOW, `ADDR_DATA_POINTER_HIGH,
        `ADDR_PROGRAM_STATUS, `ADDR_ARITH_PRIMARY, `ADDR_SECOND_OPERAND: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Shared read decode for the bus and the execution side
  function [7:0] sfr_read;
    input [7:0] addr;
    input [7:0] acc_v;
    input [7:0] b_v;
    input [7:0] sp_v;
    input [7:0] dpl_v;
    input [7:0] dph_v;
    input [7:0] psw_v;
    begin
      case (addr)
        `ADDR_STACK_POINTER:     sfr_read = sp_v;
        `ADDR_DATA_POINTER_LOW:  sfr_read = dpl_v;
        `ADDR_DATA_POINTER_HIGH: sfr_read = dph_v;
        `ADDR_PROGRAM_STATUS:    sfr_read = psw_v;
        `ADDR_ARITH_PRIMARY:     sfr_read = acc_v;
        `ADDR_SECOND_OPERAND:    sfr_read = b_v;
        default:                 sfr_read = 8'h00;
      endcase
    end
  endfunction

  // Later sources override earlier ones: bus, byte write, bit write, stack, arithmetic
  always @* begin
    next_arith_primary     = arith_primary;
    next_second_operand    = second_operand;
    next_stack_pointer     = stack_pointer;
    next_data_pointer_low  = data_pointer_low;
    next_data_pointer_high = data_pointer_high;
    next_status_bits       = status_bits;

    if (apb_write) begin
      case (apb_index)
        `ADDR_STACK_POINTER:     next_stack_pointer = PWDATA[7:0];
        `ADDR_DATA_POINTER_LOW:  next_data_pointer_low = PWDATA[7:0];
        `ADDR_DATA_POINTER_HIGH: next_data_pointer_high = PWDATA[7:0];
        `ADDR_PROGRAM_STATUS:    next_status_bits = PWDATA[7:1];
        `ADDR_ARITH_PRIMARY:     next_arith_primary = PWDATA[7:0];
        `ADDR_SECOND_OPERAND:    next_second_operand = PWDATA[7:0];
        default: begin
        end
      endcase
    end

    if (i_sfr_we) begin
      case (i_sfr_addr)
        `ADDR_STACK_POINTER:     next_stack_pointer = i_sfr_wdata;
        `ADDR_DATA_POINTER_LOW:  next_data_pointer_low = i_sfr_wdata;
        `ADDR_DATA_POINTER_HIGH: next_data_pointer_high = i_sfr_wdata;
        `ADDR_PROGRAM_STATUS:    next_status_bits = i_sfr_wdata[7:1];
        `ADDR_ARITH_PRIMARY:     next_arith_primary = i_sfr_wdata;
        `ADDR_SECOND_OPERAND:    next_second_operand = i_sfr_wdata;
        default: begin
        end
      endcase
    end

    // Only the addressed bit moves; a bit write to parity is dropped
    if (i_bit_we) begin
      case (bit_byte)
        `ADDR_ARITH_PRIMARY:  next_arith_primary[bit_pos] = i_bit_val;
        `ADDR_SECOND_OPERAND: next_second_operand[bit_pos] = i_bit_val;
        `ADDR_PROGRAM_STATUS: begin
          if (bit_pos != `PSW_PARITY)
            next_status_bits[bit_pos] = i_bit_val;
        end
        default: begin
        end
      endcase
    end

    if (i_push)
      next_stack_pointer = stack_pointer + 8'h01;
    else if (i_pop)
      next_stack_pointer = stack_pointer - 8'h01;

    if (i_arith_go) begin
      case (i_arith_op)
        `OP_ADD, `OP_ADDC: begin
          next_arith_primary                  = add_full[7:0];
          next_status_bits[`PSW_CARRY]        = add_full[8];
          next_status_bits[`PSW_AUX_CARRY]    = add_nib[4];
          next_status_bits[`PSW_SIGNED_WRAP]  = add_full[8] ^ add_low7[7];
        end
        `OP_SUBB: begin
          next_arith_primary                  = sub_full[7:0];
          next_status_bits[`PSW_CARRY]        = sub_full[8];
          next_status_bits[`PSW_AUX_CARRY]    = sub_nib[4];
          next_status_bits[`PSW_SIGNED_WRAP]  = sub_full[8] ^ sub_low7[7];
        end
        `OP_PRODUCT: begin
          next_arith_primary                  = product[7:0];
          next_second_operand                 = product[15:8];
          next_status_bits[`PSW_CARRY]        = 1'b0;
          next_status_bits[`PSW_SIGNED_WRAP]  = (product > `BYTE_MAX);
        end
        `OP_DIVIDE: begin
          // Zero divisor leaves both registers as they were
          next_arith_primary                  = quotient;
          next_second_operand                 = remainder;
          next_status_bits[`PSW_CARRY]        = 1'b0;
          next_status_bits[`PSW_SIGNED_WRAP]  = (second_operand == 8'h00);
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      arith_primary     <= `RST_ARITH_PRIMARY;
      second_operand    <= `RST_SECOND_OPERAND;
      stack_pointer     <= `RST_STACK_POINTER;
      data_pointer_low  <= `RST_DATA_POINTER_LOW;
      data_pointer_high <= `RST_DATA_POINTER_HIGH;
      status_bits       <= reset_status_word[7:1];
    end else begin
      arith_primary     <= next_arith_primary;
      second_operand    <= next_second_operand;
      stack_pointer     <= next_stack_pointer;
      data_pointer_low  <= next_data_pointer_low;
      data_pointer_high <= next_data_pointer_high;
      status_bits       <= next_status_bits;
    end
  end

  // Stack write strobe uses the already incremented pointer
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      o_stack_we    <= 1'b0;
      o_stack_addr  <= `RST_STACK_POINTER;
      o_stack_wdata <= 8'h00;
    end else begin
      o_stack_we    <= i_push;
      o_stack_addr  <= next_stack_pointer;
      o_stack_wdata <= i_push ? i_push_data : o_stack_wdata;
    end
  end

  // Registered views; bus read data is captured in the setup phase
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      PRDATA                <= 32'h0000_0000;
      o_sfr_rdata           <= 8'h00;
      o_arith_primary       <= `RST_ARITH_PRIMARY;
      o_second_operand      <= `RST_SECOND_OPERAND;
      o_stack_pointer       <= `RST_STACK_POINTER;
      o_data_pointer_pair   <= {`RST_DATA_POINTER_HIGH, `RST_DATA_POINTER_LOW};
      o_program_status_word <= `RST_PROGRAM_STATUS;
      o_bank_base           <= 8'h00;
    end else begin
      if (PSEL && !PENABLE)
        PRDATA <= {24'h00_0000, sfr_read(apb_index, arith_primary, second_operand,
                   stack_pointer, data_pointer_low, data_pointer_high, status_word)};
      o_sfr_rdata           <= sfr_read(i_sfr_addr, arith_primary, second_operand,
                               stack_pointer, data_pointer_low, data_pointer_high,
                               status_word);
      o_arith_primary       <= next_arith_primary;
      o_second_operand      <= next_second_operand;
      o_stack_pointer       <= next_stack_pointer;
      o_data_pointer_pair   <= {next_data_pointer_high, next_data_pointer_low};
      o_program_status_word <= {next_status_bits, ^next_arith_primary};
      o_bank_base           <= {3'b000, next_status_bits[`PSW_BANK_HI],
                                next_status_bits[`PSW_BANK_LO], 3'b000};
    end
  end

endmodule

// ==== tb/core_sfr_checker.sv ====
// Assertion checker for the core register set
`timescale 1ns/1ps
`include "core_sfr_regs.vh"
module core_sfr_checker (
  input wire        I_CLK,
  input wire        I_SYS_RST,
  input wire        i_bit_we,
  input wire [7:0]  i_bit_addr,
  input wire        i_bit_val,
  input wire        i_push,
  input wire [7:0]  i_push_data,
  input wire        i_arith_go,
  input wire [2:0]  i_arith_op,
  input wire [7:0]  i_arith_opnd,
  input wire        o_stack_we,
  input wire [7:0]  o_stack_addr,
  input wire [7:0]  o_stack_wdata,
  input wire [7:0]  o_arith_primary,
  input wire [7:0]  o_second_operand,
  input wire [7:0]  o_stack_pointer,
  input wire [7:0]  o_program_status_word,
  input wire [7:0]  o_bank_base
);
  wire        cin = (i_arith_op == `OP_ADDC) & o_program_status_word[`PSW_CARRY];
  wire [7:0]  lo7 = {1'b0, o_arith_primary[6:0]} + {1'b0, i_arith_opnd[6:0]} + cin;
  wire [8:0]  sum = o_arith_primary + i_arith_opnd + cin;
  wire        add_wrap = lo7[7] ^ sum[8];
  wire [15:0] prod = o_arith_primary * o_second_operand;
  wire        prod_wrap = prod > `BYTE_MAX;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_rst; $fell(I_SYS_RST) |-> o_stack_pointer == 8'h07 && o_arith_primary == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad value after reset");
  property p_par; o_program_status_word[0] == ^o_arith_primary; endproperty
  a_par: assert property (p_par) else $error("parity flag wrong");
  property p_push; i_push |=> o_stack_we && o_stack_pointer == $past(o_stack_pointer) + 8'h01
    && o_stack_addr == o_stack_pointer; endproperty
  a_push: assert property (p_push) else $error("push not pre-incremented");
  property p_pdat; i_push |=> o_stack_wdata == $past(i_push_data); endproperty
  a_pdat: assert property (p_pdat) else $error("push data wrong");
  property p_swe; o_stack_we |-> $past(i_push); endproperty
  a_swe: assert property (p_swe) else $error("stray stack write");
  property p_bank; o_bank_base == {3'b000, o_program_status_word[4:3], 3'b000}; endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");
  property p_bit; i_bit_we && i_bit_addr[7:3] == 5'h1c && !i_arith_go |=> o_arith_primary ==
    (($past(o_arith_primary) & ~(8'h01 << $past(i_bit_addr[2:0])))
    | ({7'h00, $past(i_bit_val)} << $past(i_bit_addr[2:0]))); endproperty
  a_bit: assert property (p_bit) else $error("bit write disturbed others");
  property p_addw; i_arith_go && (i_arith_op == `OP_ADD || i_arith_op == `OP_ADDC)
    |=> o_program_status_word[`PSW_SIGNED_WRAP] == $past(add_wrap); endproperty
  a_addw: assert property (p_addw) else $error("add wrap flag wrong");
  property p_prod; i_arith_go && i_arith_op == `OP_PRODUCT |=> {o_second_operand,
    o_arith_primary} == $past(prod) && o_program_status_word[2] == $past(prod_wrap); endproperty
  a_prod: assert property (p_prod) else $error("product wrong");
  property p_div0; i_arith_go && i_arith_op == `OP_DIVIDE && o_second_operand == 8'h00
    |=> o_program_status_word[`PSW_SIGNED_WRAP]; endproperty
  a_div0: assert property (p_div0) else $error("divide by zero not flagged");
endmodule
bind core_special_register_set core_sfr_checker chk (.I_CLK, .I_SYS_RST, .i_bit_we,
  .i_bit_addr, .i_bit_val, .i_push, .i_push_data, .i_arith_go, .i_arith_op, .i_arith_opnd,
  .o_stack_we, .o_stack_addr, .o_stack_wdata, .o_arith_primary, .o_second_operand,
  .o_stack_pointer, .o_program_status_word, .o_bank_base);

// ==== tb/scratchpad_model.sv ====
// Scratch-pad memory model receiving stack writes
`timescale 1ns/1ps
module scratchpad_model (
  input wire       i_clk,
  input wire       i_we,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata
);
  reg [7:0] ram [0:255];
  // Stores land at the already-advanced pointer
  always @(posedge i_clk) begin
    if (i_we) begin
      ram[i_addr] <= i_wdata;
    end
  end
endmodule

// ==== tb/core_special_register_set_bench.sv ====
// Self-checking bench for the core register set
`timescale 1ns/1ps
`include "core_sfr_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end
module core_special_register_set_bench;
  reg         I_CLK = 0, I_SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  reg  [9:0]  PADDR = 0;
  reg  [31:0] PWDATA = 0;
  wire        PREADY, PSLVERR, o_stack_we;
  wire [31:0] PRDATA;
  reg         i_sfr_we = 0, i_bit_we = 0, i_bit_val = 0, i_push = 0, i_pop = 0, i_arith_go = 0;
  reg  [7:0]  i_sfr_addr = 0, i_sfr_wdata = 0, i_bit_addr = 0, i_push_data = 0, i_arith_opnd = 0;
  reg  [2:0]  i_arith_op = 0;
  wire [7:0]  o_sfr_rdata, o_stack_addr, o_stack_wdata, o_arith_primary, o_second_operand;
  wire [7:0]  o_stack_pointer, o_program_status_word, o_bank_base;
  wire [15:0] o_data_pointer_pair;
  wire        wrap = o_program_status_word[`PSW_SIGNED_WRAP];
  integer     errors = 0, n_compared = 0, cycles = 0, i;
  reg  [31:0] rd;
  reg         err;
  reg  [7:0]  offs [6] = '{`ADDR_STACK_POINTER, `ADDR_DATA_POINTER_LOW, `ADDR_DATA_POINTER_HIGH,
                           `ADDR_PROGRAM_STATUS, `ADDR_ARITH_PRIMARY, `ADDR_SECOND_OPERAND};
  reg  [7:0]  rsts [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  core_special_register_set uut (.I_CLK, .I_SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PREADY, .PSLVERR, .PRDATA, .i_sfr_we, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata,
    .i_bit_we, .i_bit_addr, .i_bit_val, .i_push, .i_push_data, .i_pop, .o_stack_we,
    .o_stack_addr, .o_stack_wdata, .i_arith_go, .i_arith_op, .i_arith_opnd, .o_arith_primary,
    .o_second_operand, .o_stack_pointer, .o_data_pointer_pair, .o_program_status_word,
    .o_bank_base);
  scratchpad_model part (.i_clk(I_CLK), .i_we(o_stack_we), .i_addr(o_stack_addr),
    .i_wdata(o_stack_wdata));
  initial forever #12.5 I_CLK = ~I_CLK;
  task tally_and_finish;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Guards against a stalled handshake
  always @(posedge I_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  task apb(input w, input [7:0] off, input [7:0] d);
    @(posedge I_CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= {off, 2'b00};
    PWDATA <= {24'h00_0000, d};
    @(posedge I_CLK);
    PENABLE <= 1;
    do @(posedge I_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    // Outputs launched at the access edge are settled by the falling edge
    @(negedge I_CLK);
  endtask
  task step;
    @(posedge I_CLK);
    i_sfr_we <= 0;
    i_bit_we <= 0;
    i_push <= 0;
    i_pop <= 0;
    i_arith_go <= 0;
    @(negedge I_CLK);
  endtask
  task sfr_wr(input [7:0] a, input [7:0] d);
    @(posedge I_CLK);
    i_sfr_we <= 1;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    step;
  endtask
  task bit_wr(input [7:0] a, input v);
    @(posedge I_CLK);
    i_bit_we <= 1;
    i_bit_addr <= a;
    i_bit_val <= v;
    step;
  endtask
  task t_reset;
    for (i = 0; i < 6; i++) begin
      apb(0, offs[i], 8'h00);
      `CHK(rd, {24'h00_0000, rsts[i]})
    end
  endtask
  task t_apb;
    apb(1, `ADDR_DATA_POINTER_LOW, 8'h34);
    apb(1, `ADDR_DATA_POINTER_HIGH, 8'h12);
    `CHK(o_data_pointer_pair, 16'h1234)
    apb(1, `ADDR_ARITH_PRIMARY, 8'ha5);
    apb(1, `ADDR_PROGRAM_STATUS, 8'hff);
    apb(0, `ADDR_PROGRAM_STATUS, 8'h00);
    `CHK(rd[7:0], 8'hfe)
    `CHK(o_bank_base, 8'h18)
    apb(1, `ADDR_PROGRAM_STATUS, 8'h08);
    `CHK(o_bank_base, 8'h08)
    apb(0, 8'h00, 8'h00);
    `CHK({err, rd}, 33'h1_0000_0000)
  endtask
  task t_push;
    apb(1, `ADDR_STACK_POINTER, 8'h07);
    @(posedge I_CLK);
    i_push <= 1;
    i_push_data <= 8'h77;
    @(posedge I_CLK);
    i_push_data <= 8'h88;
    step;
    // The second store lands in the model one edge after the strobe
    @(posedge I_CLK);
    @(negedge I_CLK);
    `CHK({part.ram[8], part.ram[9], o_stack_pointer}, 24'h77_8809)
    @(posedge I_CLK);
    i_pop <= 1;
    step;
    `CHK({o_stack_pointer, o_stack_addr, o_stack_we}, 17'h1010)
  endtask
  task t_midreset;
    @(posedge I_CLK);
    I_SYS_RST <= 1;
    repeat (2) @(posedge I_CLK);
    I_SYS_RST <= 0;
    @(posedge I_CLK);
    @(negedge I_CLK);
    `CHK({o_stack_pointer, o_stack_addr, o_arith_primary, o_second_operand}, 32'h0707_0000)
    `CHK({o_data_pointer_pair, o_program_status_word, o_bank_base}, 32'h0000_0000)
  endtask
  task t_bits;
    sfr_wr(`ADDR_ARITH_PRIMARY, 8'h00);
    bit_wr(8'he7, 1);
    bit_wr(8'he0, 1);
    `CHK(o_arith_primary, 8'h81)
    sfr_wr(`ADDR_SECOND_OPERAND, 8'hff);
    bit_wr(8'hf3, 0);
    `CHK(o_second_operand, 8'hf7)
    // Read port shows the value held before the edge that took the bit write
    `CHK(o_sfr_rdata, 8'hff)
    bit_wr(8'hd0, 1);
    `CHK(o_program_status_word, 8'h08)
  endtask
  task arith(input [2:0] op, input [7:0] a, input [7:0] b, input [7:0] d, input [7:0] ea,
             input [7:0] eb, input ew);
    sfr_wr(`ADDR_ARITH_PRIMARY, a);
    sfr_wr(`ADDR_SECOND_OPERAND, b);
    @(posedge I_CLK);
    i_arith_go <= 1;
    i_arith_op <= op;
    i_arith_opnd <= d;
    step;
    `CHK({o_arith_primary, o_second_operand, wrap}, {ea, eb, ew})
  endtask
  initial begin
    repeat (16) @(posedge I_CLK);
    I_SYS_RST <= 0;
    @(posedge I_CLK);
    t_reset;
    t_apb;
    t_push;
    t_bits;
    // Rows run in order: the carry left by one feeds the next ADDC or SUBB row
    arith(`OP_ADD, 8'h7f, 8'h00, 8'h01, 8'h80, 8'h00, 1);
    arith(`OP_ADD, 8'hff, 8'h00, 8'h01, 8'h00, 8'h00, 0);
    arith(`OP_ADDC, 8'h3f, 8'h00, 8'h40, 8'h80, 8'h00, 1);
    arith(`OP_SUBB, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h00, 1);
    arith(`OP_PRODUCT, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02, 1);
    arith(`OP_PRODUCT, 8'h02, 8'h03, 8'h00, 8'h06, 8'h00, 0);
    arith(`OP_DIVIDE, 8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 1);
    arith(`OP_DIVIDE, 8'h07, 8'h02, 8'h00, 8'h03, 8'h01, 0);
    // Reset again with every register away from its reset value
    t_midreset;
    tally_and_finish;
  end
endmodule
